// file: core/ophc_regs.sv
// OFDM PHY header configuration and status register bank with APB slave
// Notes on behaviour
// - Transmit MCS selects payload coding and fills rate field low bits, upper zero.
// - MCS codes 0..6 decode to BPSK/QPSK/16-QAM with rates and repetition.
// - Reserved header bits 21, 18, 17, 5 are transmitted as written, no other effect.
// - Receive header status updates only when frame-start interrupt is raised.
// - Receive status bits 7..4 show reserved header bits 21, 18, 17, 5.
// - Receive MCS status holds low three rate bits of last frame.
// - Spurious compensation active while its enable bit is one.
// - Receive seed status mirrors header scrambler field and seeds descrambler.
// - Transmit seed select picks scrambler seed and fills header scrambler field.
// - Interleave bit zero gives one symbol depth, one gives spreading factor.
// - Bandwidth option codes 0..3 select OFDM options 1..4.
// - Smaller preamble threshold values make detection more sensitive.
// - Override enabled restarts sync when symbol power rises over 12 dB.
// - Frame-start raised only for valid header checksum and nonzero length.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module ophc_regs
  import ophc_pkg::*;
#(
  parameter int FREQ_SPREAD_W = 3
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ,
  // Receiver header decode result
  input wire logic RX_HDR_DONE,
  input wire logic RX_HDR_CRC_OK,
  input wire logic [11:0] RX_HDR_LENGTH,
  input wire logic [OPHC_RATE_W-1:0] RX_HDR_RATE,
  input wire logic [3:0] RX_HDR_RESERVED,
  input wire logic [1:0] RX_HDR_SCRAMBLER,
  // Receiver power tracking
  input wire logic RX_IN_FRAME,
  input wire logic RX_SYM_POWER_STB,
  input wire logic [7:0] RX_SYM_POWER_DB,
  // Transmit header and modem control
  output logic [OPHC_RATE_W-1:0] TX_HDR_RATE,
  output logic [3:0] TX_HDR_RESERVED,
  output logic [1:0] TX_HDR_SCRAMBLER,
  output logic [8:0] TX_SCRAMBLER_SEED,
  output logic [1:0] TX_MODULATION,
  output logic [1:0] TX_CODE_RATE,
  output logic [1:0] TX_FREQ_REPEAT,
  // Receiver control
  output logic [8:0] RX_DESCRAMBLER_SEED,
  output logic RX_FRAME_START,
  output logic RX_SYNC_RESTART,
  output logic RX_SPUR_COMP_EN,
  output logic RX_LOW_FREQ_OFFSET,
  output logic [1:0] RX_BANDWIDTH_OPTION,
  output logic [FREQ_SPREAD_W-1:0] RX_INTERLEAVE_DEPTH,
  output logic [2:0] RX_PREAMBLE_THRESHOLD,
  input wire logic [FREQ_SPREAD_W-1:0] RX_FREQ_SPREAD
);

  typedef struct packed {
    logic [7:0] tx_hdr;
    logic [7:0] rx_hdr;
    logic [7:0] phy_cfg;
    logic [7:0] switches;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic fs_pulse;
    logic resync_pulse;
    logic [7:0] last_pwr;
    logic pwr_valid;
  } ophc_state_s;

  ophc_state_s st_q;
  ophc_state_s st_d;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic frame_start;
  logic resync;
  logic [7:0] wbyte;
  logic [8:0] pwr_diff;

  function automatic logic [8:0] seed_of(input logic [1:0] code);
    logic [8:0] s;
    s = OPHC_SEED0;
    unique case (code)
      2'h0: s = OPHC_SEED0;
      2'h1: s = OPHC_SEED1;
      2'h2: s = OPHC_SEED2;
      2'h3: s = OPHC_SEED3;
    endcase
    return s;
  endfunction

  // Only byte lane 0 carries register data
  assign wbyte = PSTRB[0] ? PWDATA[7:0] : 8'h00;
  assign wr_en = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign addr_ok = (PADDR == OPHC_TX_HDR_OFS) || (PADDR == OPHC_RX_HDR_OFS) ||
                   (PADDR == OPHC_PHY_CFG_OFS) || (PADDR == OPHC_SWITCH_OFS) ||
                   (PADDR == OPHC_IRQ_STAT_OFS) || (PADDR == OPHC_IRQ_MASK_OFS);

  assign frame_start = RX_HDR_DONE && RX_HDR_CRC_OK && (RX_HDR_LENGTH != 12'h000);

  assign pwr_diff = {1'b0, RX_SYM_POWER_DB} - {1'b0, st_q.last_pwr};
  assign resync = st_q.switches[OPHC_RXO_BIT] && RX_IN_FRAME && RX_SYM_POWER_STB &&
                  st_q.pwr_valid && (RX_SYM_POWER_DB > st_q.last_pwr) &&
                  (pwr_diff[7:0] > OPHC_RESYNC_DB);

  always_comb begin
    st_d = st_q;
    st_d.fs_pulse = frame_start;
    st_d.resync_pulse = resync;
    if (RX_SYM_POWER_STB && RX_IN_FRAME) begin
      st_d.last_pwr = RX_SYM_POWER_DB;
      st_d.pwr_valid = 1'b1;
    end
    // Restarted sync measures power afresh
    if (!RX_IN_FRAME || resync) begin
      st_d.pwr_valid = 1'b0;
    end
    if (wr_en) begin
      unique case (PADDR)
        OPHC_TX_HDR_OFS: st_d.tx_hdr = wbyte & OPHC_TX_HDR_WMASK;
        OPHC_RX_HDR_OFS: st_d.rx_hdr = (st_q.rx_hdr & ~OPHC_RX_HDR_WMASK) | (wbyte & OPHC_RX_HDR_WMASK);
        OPHC_PHY_CFG_OFS: st_d.phy_cfg = (st_q.phy_cfg & ~OPHC_PHY_CFG_WMASK) | (wbyte & OPHC_PHY_CFG_WMASK);
        OPHC_SWITCH_OFS: st_d.switches = wbyte & OPHC_SWITCH_WMASK;
        OPHC_IRQ_STAT_OFS: st_d.irq_stat = st_q.irq_stat & ~(wbyte[1:0] & OPHC_IRQ_WMASK);
        OPHC_IRQ_MASK_OFS: st_d.irq_mask = wbyte[1:0] & OPHC_IRQ_WMASK;
        default: ;
      endcase
    end
    if (frame_start) begin
      st_d.rx_hdr[OPHC_RSV21_BIT:OPHC_RSV5_BIT] = RX_HDR_RESERVED;
      st_d.rx_hdr[OPHC_MCS_LSB+:3] = RX_HDR_RATE[2:0];
      st_d.phy_cfg[OPHC_RX_SEED_STATUS_LSB+:2] = RX_HDR_SCRAMBLER;
    end
    // Set wins over a same-cycle clear
    if (frame_start) begin
      st_d.irq_stat[OPHC_IRQ_FRAME_START] = 1'b1;
    end
    if (resync) begin
      st_d.irq_stat[OPHC_IRQ_RESYNC] = 1'b1;
    end
    if (rd_en) begin
      st_d.rdata = 32'h0000_0000;
      unique case (PADDR)
        OPHC_TX_HDR_OFS: st_d.rdata[7:0] = st_q.tx_hdr;
        OPHC_RX_HDR_OFS: st_d.rdata[7:0] = st_q.rx_hdr;
        OPHC_PHY_CFG_OFS: st_d.rdata[7:0] = st_q.phy_cfg;
        OPHC_SWITCH_OFS: st_d.rdata[7:0] = st_q.switches;
        OPHC_IRQ_STAT_OFS: st_d.rdata[1:0] = st_q.irq_stat;
        OPHC_IRQ_MASK_OFS: st_d.rdata[1:0] = st_q.irq_mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= '0;
      st_q.tx_hdr <= OPHC_TX_HDR_RST;
      st_q.rx_hdr <= OPHC_RX_HDR_RST;
      st_q.phy_cfg <= OPHC_PHY_CFG_RST;
      st_q.switches <= OPHC_SWITCH_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Read data set up in setup phase, so no wait states
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = st_q.rdata;
  assign IRQ = |(st_q.irq_stat & st_q.irq_mask);

  assign TX_HDR_RATE = {{(OPHC_RATE_W-3){1'b0}}, st_q.tx_hdr[OPHC_MCS_LSB+:3]};
  assign TX_HDR_RESERVED = st_q.tx_hdr[OPHC_RSV21_BIT:OPHC_RSV5_BIT];
  assign TX_HDR_SCRAMBLER = st_q.phy_cfg[OPHC_TX_SEED_SELECT_LSB+:2];
  assign TX_SCRAMBLER_SEED = seed_of(st_q.phy_cfg[OPHC_TX_SEED_SELECT_LSB+:2]);
  assign RX_DESCRAMBLER_SEED = seed_of(st_q.phy_cfg[OPHC_RX_SEED_STATUS_LSB+:2]);

  always_comb begin
    TX_MODULATION = OPHC_MOD_BPSK;
    TX_CODE_RATE = OPHC_CODE_R12;
    TX_FREQ_REPEAT = 2'h0;
    unique case (st_q.tx_hdr[OPHC_MCS_LSB+:3])
      OPHC_BPSK_R12_X4: TX_FREQ_REPEAT = 2'h2;
      OPHC_BPSK_R12_X2: TX_FREQ_REPEAT = 2'h1;
      OPHC_QPSK_R12_X2: begin
        TX_MODULATION = OPHC_MOD_QPSK;
        TX_FREQ_REPEAT = 2'h1;
      end
      OPHC_QPSK_R12: TX_MODULATION = OPHC_MOD_QPSK;
      OPHC_QPSK_R34: begin
        TX_MODULATION = OPHC_MOD_QPSK;
        TX_CODE_RATE = OPHC_CODE_R34;
      end
      OPHC_QAM16_R12: TX_MODULATION = OPHC_MOD_QAM16;
      OPHC_QAM16_R34: begin
        TX_MODULATION = OPHC_MOD_QAM16;
        TX_CODE_RATE = OPHC_CODE_R34;
      end
      // Code 7 undefined: falls back to the most robust mode
      default: TX_FREQ_REPEAT = 2'h2;
    endcase
  end

  assign RX_FRAME_START = st_q.fs_pulse;
  assign RX_SYNC_RESTART = st_q.resync_pulse;
  assign RX_SPUR_COMP_EN = st_q.rx_hdr[OPHC_SPC_BIT];
  assign RX_LOW_FREQ_OFFSET = st_q.phy_cfg[OPHC_LFO_BIT];
  assign RX_BANDWIDTH_OPTION = st_q.phy_cfg[OPHC_OPT_LSB+:2];
  assign RX_INTERLEAVE_DEPTH = st_q.phy_cfg[OPHC_POI_BIT] ? RX_FREQ_SPREAD :
                               {{(FREQ_SPREAD_W-1){1'b0}}, 1'b1};
  assign RX_PREAMBLE_THRESHOLD = st_q.switches[OPHC_PDT_LSB+:3];

endmodule

// file: core/ophc_pkg.sv
// Register map, field layouts and encodings for the OFDM header config bank
package ophc_pkg;
  // Register byte offsets
  localparam logic [7:0] OPHC_TX_HDR_OFS = 8'h00;
  localparam logic [7:0] OPHC_RX_HDR_OFS = 8'h04;
  localparam logic [7:0] OPHC_PHY_CFG_OFS = 8'h08;
  localparam logic [7:0] OPHC_SWITCH_OFS = 8'h0c;
  localparam logic [7:0] OPHC_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] OPHC_IRQ_MASK_OFS = 8'h14;
  // Reset values
  localparam logic [7:0] OPHC_TX_HDR_RST = 8'h00;
  localparam logic [7:0] OPHC_RX_HDR_RST = 8'h00;
  localparam logic [7:0] OPHC_PHY_CFG_RST = 8'h00;
  localparam logic [7:0] OPHC_SWITCH_RST = 8'h10;
  // Writable bit masks
  localparam logic [7:0] OPHC_TX_HDR_WMASK = 8'hf7;
  localparam logic [7:0] OPHC_RX_HDR_WMASK = 8'h08;
  localparam logic [7:0] OPHC_PHY_CFG_WMASK = 8'h3f;
  localparam logic [7:0] OPHC_SWITCH_WMASK = 8'hff;
  localparam logic [1:0] OPHC_IRQ_WMASK = 2'h3;
  // Interrupt status bits
  localparam int OPHC_IRQ_FRAME_START = 0;
  localparam int OPHC_IRQ_RESYNC = 1;
  // Field positions
  localparam int OPHC_MCS_LSB = 0;
  localparam int OPHC_RSV5_BIT = 4;
  localparam int OPHC_RSV17_BIT = 5;
  localparam int OPHC_RSV18_BIT = 6;
  localparam int OPHC_RSV21_BIT = 7;
  localparam int OPHC_SPC_BIT = 3;
  localparam int OPHC_OPT_LSB = 0;
  localparam int OPHC_POI_BIT = 2;
  localparam int OPHC_LFO_BIT = 3;
  localparam int OPHC_TX_SEED_SELECT_LSB = 4;
  localparam int OPHC_RX_SEED_STATUS_LSB = 6;
  localparam int OPHC_RXO_BIT = 4;
  localparam int OPHC_PDT_LSB = 5;
  // Header rate field width and override threshold
  localparam int OPHC_RATE_W = 5;
  localparam logic [7:0] OPHC_RESYNC_DB = 8'h0c;
  // Scrambler seeds
  localparam logic [8:0] OPHC_SEED0 = 9'h017;
  localparam logic [8:0] OPHC_SEED1 = 9'h177;
  localparam logic [8:0] OPHC_SEED2 = 9'h01c;
  localparam logic [8:0] OPHC_SEED3 = 9'h17c;
  typedef enum logic [2:0] {
    OPHC_BPSK_R12_X4 = 3'h0,
    OPHC_BPSK_R12_X2 = 3'h1,
    OPHC_QPSK_R12_X2 = 3'h2,
    OPHC_QPSK_R12 = 3'h3,
    OPHC_QPSK_R34 = 3'h4,
    OPHC_QAM16_R12 = 3'h5,
    OPHC_QAM16_R34 = 3'h6
  } ophc_mcs_e;
  typedef enum logic [1:0] {
    OPHC_MOD_BPSK = 2'h0,
    OPHC_MOD_QPSK = 2'h1,
    OPHC_MOD_QAM16 = 2'h2
  } ophc_mod_e;
  typedef enum logic [1:0] {
    OPHC_CODE_R12 = 2'h0,
    OPHC_CODE_R34 = 2'h1
  } ophc_code_e;
endpackage

// file: dv/ophc_props.sv
// Assertion checker for the OFDM header config bank
`timescale 1ns/1ps
module ophc_props
  import ophc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Receiver side
  input wire logic RX_HDR_DONE,
  input wire logic RX_HDR_CRC_OK,
  input wire logic [11:0] RX_HDR_LENGTH,
  input wire logic [1:0] RX_HDR_SCRAMBLER,
  input wire logic RX_IN_FRAME,
  input wire logic RX_SYM_POWER_STB,
  input wire logic [8:0] RX_DESCRAMBLER_SEED,
  input wire logic RX_FRAME_START,
  input wire logic RX_SYNC_RESTART,
  input wire logic IRQ,
  // Transmit side
  input wire logic [4:0] TX_HDR_RATE,
  input wire logic [1:0] TX_HDR_SCRAMBLER,
  input wire logic [8:0] TX_SCRAMBLER_SEED,
  input wire logic [1:0] TX_MODULATION,
  input wire logic [1:0] TX_CODE_RATE,
  input wire logic [1:0] TX_FREQ_REPEAT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  function automatic logic [8:0] sd(input logic [1:0] c);
    return c == 2'h0 ? OPHC_SEED0 : c == 2'h1 ? OPHC_SEED1 : c == 2'h2 ? OPHC_SEED2 : OPHC_SEED3;
  endfunction
  wire fs_ok = RX_HDR_DONE && RX_HDR_CRC_OK && RX_HDR_LENGTH != 12'h000;
  property p_rate; TX_HDR_RATE[4:3] == 2'h0; endproperty
  a_rate: assert property (p_rate) else $error("rate upper bits set");
  property p_fs; fs_ok |=> RX_FRAME_START; endproperty
  a_fs: assert property (p_fs) else $error("frame start missing");
  property p_fs_only; RX_FRAME_START |-> $past(fs_ok); endproperty
  a_fs_only: assert property (p_fs_only) else $error("frame start without valid header");
  property p_hold; !$past(fs_ok) |-> $stable(RX_DESCRAMBLER_SEED); endproperty
  a_hold: assert property (p_hold) else $error("rx seed changed outside capture");
  property p_rxseed; RX_FRAME_START |-> RX_DESCRAMBLER_SEED == sd($past(RX_HDR_SCRAMBLER)); endproperty
  a_rxseed: assert property (p_rxseed) else $error("rx seed mapping wrong");
  property p_resync; RX_SYNC_RESTART |-> $past(RX_IN_FRAME && RX_SYM_POWER_STB); endproperty
  a_resync: assert property (p_resync) else $error("restart without strobe in frame");
  property p_dec; TX_CODE_RATE == OPHC_CODE_R34 |-> TX_FREQ_REPEAT == 2'h0 && TX_MODULATION != OPHC_MOD_BPSK;
  endproperty
  a_dec: assert property (p_dec) else $error("coding decode wrong");
  property p_txseed; TX_SCRAMBLER_SEED == sd(TX_HDR_SCRAMBLER); endproperty
  a_txseed: assert property (p_txseed) else $error("tx seed mapping wrong");
  c_fs: cover property (RX_FRAME_START);
  c_rs: cover property (RX_SYNC_RESTART);
  c_irq: cover property ($fell(IRQ));
endmodule
bind ophc_regs ophc_props ophc_props_inst (.*);

// file: dv/tb_top.sv
// Self-checking testbench for the OFDM header config bank
`timescale 1ns/1ps
module tb_top;
  import ophc_pkg::*;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, IRQ, err;
  logic [7:0] PADDR = 0, RX_SYM_POWER_DB = 0, d;
  logic [31:0] PWDATA = 0, PRDATA, rd, erx;
  logic [3:0] PSTRB = 4'h1, RX_HDR_RESERVED = 0, TX_HDR_RESERVED;
  logic RX_HDR_DONE = 0, RX_HDR_CRC_OK = 0, RX_IN_FRAME = 0, RX_SYM_POWER_STB = 0;
  logic [11:0] RX_HDR_LENGTH = 0;
  logic [4:0] RX_HDR_RATE = 0, TX_HDR_RATE;
  logic [1:0] RX_HDR_SCRAMBLER = 0, TX_HDR_SCRAMBLER, TX_MODULATION, TX_CODE_RATE, TX_FREQ_REPEAT;
  logic [8:0] TX_SCRAMBLER_SEED, RX_DESCRAMBLER_SEED;
  logic RX_FRAME_START, RX_SYNC_RESTART, RX_SPUR_COMP_EN, RX_LOW_FREQ_OFFSET;
  logic [1:0] RX_BANDWIDTH_OPTION;
  logic [2:0] RX_INTERLEAVE_DEPTH, RX_PREAMBLE_THRESHOLD, RX_FREQ_SPREAD = 3'h5;
  int fails = 0, check_count = 0;
  ophc_regs ophc_regs_inst (.*);
  initial forever #20 CLK = ~CLK;
  function automatic logic [8:0] seedf(input logic [1:0] c);
    logic [8:0] t[4] = '{9'h017, 9'h177, 9'h01c, 9'h17c};
    return t[c];
  endfunction
  // Modulation, code rate, repetition per coding code
  function automatic logic [5:0] decf(input logic [2:0] m);
    logic [5:0] t[8] = '{6'h02, 6'h01, 6'h11, 6'h10, 6'h14, 6'h20, 6'h24, 6'h02};
    return t[m];
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 9);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (n >= 9) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic frame(input logic c, input logic [11:0] n, input logic e);
    @(posedge CLK);
    RX_HDR_DONE <= 1;
    RX_HDR_CRC_OK <= c;
    RX_HDR_LENGTH <= n;
    RX_HDR_RATE <= 5'($urandom);
    RX_HDR_RESERVED <= 4'($urandom);
    RX_HDR_SCRAMBLER <= 2'($urandom);
    @(posedge CLK);
    RX_HDR_DONE <= 0;
    @(posedge CLK);
    chk("frame_start", RX_FRAME_START, e);
  endtask
  task automatic pwr(input logic [7:0] v, input logic e);
    @(posedge CLK);
    RX_SYM_POWER_STB <= 1;
    RX_SYM_POWER_DB <= v;
    @(posedge CLK);
    RX_SYM_POWER_STB <= 0;
    @(posedge CLK);
    chk("restart", RX_SYNC_RESTART, e);
  endtask
  initial begin
    void'($urandom(99894));
    repeat (20) @(posedge CLK);
    RESET <= 0;
    for (int i = 0; i < 6; i++) begin
      apb(0, 8'(i * 4), 0);
      chk("reset_value", rd, i == 3 ? 32'h10 : 32'h0);
    end
    apb(0, 8'h18, 0);
    chk("unmapped_err", err, 1);
    chk("unmapped_data", rd, 0);
    $display("reset test done");
    for (int m = 0; m < 8; m++) begin
      d = 8'($urandom);
      d[2:0] = 3'(m);
      RX_FREQ_SPREAD <= 3'($urandom);
      apb(1, OPHC_TX_HDR_OFS, d);
      apb(0, OPHC_TX_HDR_OFS, 0);
      chk("tx_readback", rd, d & 8'hf7);
      chk("tx_rate", TX_HDR_RATE, {2'h0, d[2:0]});
      chk("tx_reserved", TX_HDR_RESERVED, d[7:4]);
      chk("tx_decode", {TX_MODULATION, TX_CODE_RATE, TX_FREQ_REPEAT}, decf(d[2:0]));
      apb(1, OPHC_PHY_CFG_OFS, d);
      apb(1, OPHC_SWITCH_OFS, d);
      apb(0, OPHC_PHY_CFG_OFS, 0);
      chk("cfg_readback", rd, d & 8'h3f);
      chk("tx_seed", {TX_HDR_SCRAMBLER, TX_SCRAMBLER_SEED}, {d[5:4], seedf(d[5:4])});
      chk("bw_option", RX_BANDWIDTH_OPTION, d[1:0]);
      chk("low_offset", RX_LOW_FREQ_OFFSET, d[3]);
      chk("depth", RX_INTERLEAVE_DEPTH, d[2] ? RX_FREQ_SPREAD : 3'h1);
      chk("threshold", RX_PREAMBLE_THRESHOLD, d[7:5]);
    end
    // Lane 0 strobe low: write must not land
    PSTRB <= 4'he;
    apb(1, OPHC_SWITCH_OFS, 32'h0);
    PSTRB <= 4'h1;
    apb(0, OPHC_SWITCH_OFS, 0);
    chk("strobe_off", rd, d);
    $display("tx config test done");
    apb(1, OPHC_IRQ_MASK_OFS, 3);
    apb(1, OPHC_RX_HDR_OFS, 32'hff);
    apb(0, OPHC_RX_HDR_OFS, 0);
    chk("rx_status_ro", rd, 32'h08);
    chk("spur_comp", RX_SPUR_COMP_EN, 1);
    frame(1, 12'(1 + $urandom_range(4094)), 1);
    erx = {RX_HDR_RESERVED, 1'b1, RX_HDR_RATE[2:0]};
    chk("rx_seed", RX_DESCRAMBLER_SEED, seedf(RX_HDR_SCRAMBLER));
    apb(0, OPHC_PHY_CFG_OFS, 0);
    chk("rx_seed_status", rd[7:6], RX_HDR_SCRAMBLER);
    apb(0, OPHC_RX_HDR_OFS, 0);
    chk("rx_status", rd, erx);
    chk("irq_set", IRQ, 1);
    apb(1, OPHC_IRQ_STAT_OFS, 1);
    // Clear lands at the access edge, seen one cycle on
    @(posedge CLK);
    chk("irq_clear", IRQ, 0);
    frame(0, 12'h5, 0);
    frame(1, 12'h0, 0);
    apb(0, OPHC_RX_HDR_OFS, 0);
    chk("rx_status_kept", rd, erx);
    chk("irq_quiet", IRQ, 0);
    $display("frame test done");
    apb(1, OPHC_SWITCH_OFS, 32'h10);
    RX_IN_FRAME <= 1;
    pwr(8'd40, 0);
    pwr(8'd52, 0);
    pwr(8'd65, 1);
    apb(1, OPHC_SWITCH_OFS, 0);
    // Fresh reference first, so the big step is a real test of the switch
    pwr(8'd30, 0);
    pwr(8'd100, 0);
    RX_IN_FRAME <= 0;
    apb(0, OPHC_IRQ_STAT_OFS, 0);
    chk("resync_status", rd, 32'h2);
    $display("override test done");
    give_verdict();
  end
endmodule
